// file: core/audio_clock_defines.vh
// Register indices, field positions, reset values and constants of the audio clock generator.
`ifndef AUDIO_CLOCK_DEFINES_VH
`define AUDIO_CLOCK_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_CLOCK_SOURCE_SELECT   8'h04
`define IDX_PLL_PR                8'h05
`define IDX_PLL_J                 8'h06
`define IDX_PLL_D_HIGH            8'h07
`define IDX_PLL_D_LOW             8'h08
`define IDX_CONV_DIV              8'h12
`define IDX_MOD_DIV               8'h13
`define IDX_OVERSAMPLING          8'h14
`define IDX_INSTRUCTION_COUNT     8'h15
`define IDX_FILTER_MODE_SELECT    8'h3d
`define IDX_CLOCK_STATUS          8'h40

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CONV_SRC_LSB              0
`define PLL_SRC_LSB               2
`define PLL_EN_BIT                7
`define PLL_P_LSB                 4
`define PLL_R_LSB                 0
`define DIV_EN_BIT                7

// ----------------------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------------------
`define SRC_MCLK                  2'h0
`define SRC_BCLK                  2'h1
`define SRC_PLL                   2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CLOCK_SOURCE_SELECT   8'h00
`define RST_PLL_PR                8'h11
`define RST_PLL_J                 6'h04
`define RST_PLL_D                 14'h0000
`define RST_CONV_DIV              8'h81
`define RST_MOD_DIV               8'h81
`define RST_OVERSAMPLING          8'h80
`define RST_INSTRUCTION_COUNT     8'h80
`define RST_FILTER_MODE_SELECT    8'h00

// ----------------------------------------------------------------------------
// Arithmetic constants
// ----------------------------------------------------------------------------
`define FRAC_SCALE                20'h02710
`define FRAC_MAX                  14'h270f
`define CREDIT_SCALE              26'h0002710
`define CREDIT_MAX                26'h3ffffff
`define PROC_BLOCK_INSTR          16'h00bc

`endif

// file: core/pin_sync.v
// Two-flop synchroniser for a pin that is asynchronous to the system clock.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
	input  wire sys_clk,
	input  wire rst_b,
	input  wire pin_in,
	output reg  level_q
);
	reg meta_q;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			meta_q  <= 1'b0;
			level_q <= 1'b0;
		end else begin
			meta_q  <= pin_in;
			level_q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// file: core/tick_divider.v
// Integer divider of a one-cycle tick stream; the divisor is one or more.
`timescale 1ns/100ps
`default_nettype none
module tick_divider (
	input  wire       sys_clk,
	input  wire       rst_b,
	input  wire       enable,
	input  wire [8:0] divisor,
	input  wire       tick_in,
	output reg        tick_q
);
	reg  [8:0] count_q;
	wire [8:0] count_inc = count_q + 9'h001;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			count_q <= 9'h000;
			tick_q  <= 1'b0;
		end else if (!enable) begin
			count_q <= 9'h000;
			tick_q  <= 1'b0;
		end else if (tick_in) begin
			if (count_inc >= divisor) begin
				count_q <= 9'h000;
				tick_q  <= 1'b1;
			end else begin
				count_q <= count_inc;
				tick_q  <= 1'b0;
			end
		end else begin
			tick_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: core/audio_clock_generator_pll.v
// Audio clock generator: source selection, fractional PLL rate model and cascaded dividers.
//
// Behaviour
// - Converter reference is master clock pin, bit clock pin or PLL, per source field.
// - PLL reference is master clock pin or bit clock pin, per second source field.
// - With PLL on, sample rate is ref times K times R over dividers and P.
// - Pre-divider P programmable 1 to 8.
// - Multiplier R programmable 1 to 16.
// - K equals J plus D over ten thousand; J 1..63, D 0..9999.
// - Master clock pin feeds internal master clock through divider or PLL.
// - Bit clock pin may also source the internal master clock.
// - Dividers span standard audio rates from 8 kHz to 96 kHz.
// - Cascaded dividers produce converter clocks and filter clocks from the reference.
//
// All clocks are represented as one-cycle ticks of sys_clk, so no derived rate
// can exceed the system clock; the PLL output is limited to one tick a cycle.
`timescale 1ns/100ps
`default_nettype none
`include "audio_clock_defines.vh"
module audio_clock_generator_pll (
	input  wire        sys_clk,
	input  wire        rst_b,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output reg         pslverr,
	input  wire        mclk_pin,
	input  wire        bclk_pin,
	output reg         pll_tick,
	output reg         converter_reference_tick,
	output wire        converter_clock_tick,
	output wire        modulator_clock_tick,
	output wire        sample_tick,
	output reg         clock_rate_low
);

	// ------------------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------------------
	// Each register keeps only the bits it implements; other read bits are zero.
	reg  [7:0]  clock_source_select_q;
	reg  [7:0]  pll_pr_q;
	reg  [5:0]  pll_j_q;
	reg  [13:0] pll_d_q;
	reg  [7:0]  conv_div_q;
	reg  [7:0]  mod_div_q;
	reg  [7:0]  oversampling_q;
	reg  [7:0]  instruction_count_setting_q;
	reg  [7:0]  filter_mode_select_q;
	reg  [15:0] conv_per_sample_q;

	// ------------------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------------------
	wire [7:0]  reg_idx    = paddr[9:2];
	wire        setup      = psel && !penable;
	wire        access_wr  = psel && penable && pwrite;
	wire        addr_align = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	reg         idx_hit;
	reg  [31:0] read_value;
	// Both fraction forms are rebuilt from the byte being written.
	wire [13:0] d_write    = {pwdata[5:0], pll_d_q[7:0]};
	wire [13:0] d_write_lo = {pll_d_q[13:8], pwdata[7:0]};

	// Every access completes at once; nothing here needs wait states.
	assign pready = 1'b1;

	always @* begin
		idx_hit    = 1'b1;
		read_value = 32'h00000000;
		case (reg_idx)
			`IDX_CLOCK_SOURCE_SELECT: read_value[7:0] = clock_source_select_q;
			`IDX_PLL_PR:              read_value[7:0] = pll_pr_q;
			`IDX_PLL_J:               read_value[5:0] = pll_j_q;
			`IDX_PLL_D_HIGH:          read_value[5:0] = pll_d_q[13:8];
			`IDX_PLL_D_LOW:           read_value[7:0] = pll_d_q[7:0];
			`IDX_CONV_DIV:            read_value[7:0] = conv_div_q;
			`IDX_MOD_DIV:             read_value[7:0] = mod_div_q;
			`IDX_OVERSAMPLING:        read_value[7:0] = oversampling_q;
			`IDX_INSTRUCTION_COUNT:   read_value[7:0] = instruction_count_setting_q;
			`IDX_FILTER_MODE_SELECT:  read_value[7:0] = filter_mode_select_q;
			`IDX_CLOCK_STATUS:        read_value      = {15'h0000, clock_rate_low,
			                                             conv_per_sample_q};
			default:                  idx_hit = 1'b0;
		endcase
		if (!addr_align) begin
			idx_hit = 1'b0;
		end
	end

	// Read data and the error answer are captured in the setup cycle so that
	// both come from flip-flops during the access phase.
	// A transfer therefore sees the register as it stood in its setup cycle.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= (idx_hit && !pwrite) ? read_value : 32'h00000000;
			pslverr <= !idx_hit;
		end
	end

	// ------------------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------------------
	// A write to the read-only status index is accepted and changes nothing.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			clock_source_select_q       <= `RST_CLOCK_SOURCE_SELECT;
			pll_pr_q                    <= `RST_PLL_PR;
			pll_j_q                     <= `RST_PLL_J;
			pll_d_q                     <= `RST_PLL_D;
			conv_div_q                  <= `RST_CONV_DIV;
			mod_div_q                   <= `RST_MOD_DIV;
			oversampling_q              <= `RST_OVERSAMPLING;
			instruction_count_setting_q <= `RST_INSTRUCTION_COUNT;
			filter_mode_select_q        <= `RST_FILTER_MODE_SELECT;
		end else if (access_wr && idx_hit) begin
			case (reg_idx)
				`IDX_CLOCK_SOURCE_SELECT: clock_source_select_q <= pwdata[7:0];
				`IDX_PLL_PR:              pll_pr_q <= pwdata[7:0];
				`IDX_PLL_J:               pll_j_q <= pwdata[5:0];
				// A fraction above 9999 is clamped so K never reaches J plus one.
				// Each byte is checked against the other as it stands, so write the
				// high byte first and the low byte last.
				`IDX_PLL_D_HIGH: begin
					pll_d_q <= (d_write > `FRAC_MAX) ? `FRAC_MAX : d_write;
				end
				`IDX_PLL_D_LOW: begin
					pll_d_q <= (d_write_lo > `FRAC_MAX) ? `FRAC_MAX : d_write_lo;
				end
				`IDX_CONV_DIV:            conv_div_q <= pwdata[7:0];
				`IDX_MOD_DIV:             mod_div_q <= pwdata[7:0];
				`IDX_OVERSAMPLING:        oversampling_q <= pwdata[7:0];
				`IDX_INSTRUCTION_COUNT:   instruction_count_setting_q <= pwdata[7:0];
				`IDX_FILTER_MODE_SELECT:  filter_mode_select_q <= pwdata[7:0];
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------------------
	wire mclk_level;
	wire bclk_level;
	reg  mclk_last_q;
	reg  bclk_last_q;

	// Both pins are asynchronous to sys_clk and pass two flip-flops first.
	pin_sync u_mclk_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.pin_in  (mclk_pin),
		.level_q (mclk_level)
	);

	pin_sync u_bclk_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.pin_in  (bclk_pin),
		.level_q (bclk_level)
	);

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			mclk_last_q <= 1'b0;
			bclk_last_q <= 1'b0;
		end else begin
			mclk_last_q <= mclk_level;
			bclk_last_q <= bclk_level;
		end
	end

	// The edge detectors reset low, the idle level of both pins, so leaving
	// reset never makes a false reference edge.
	wire mclk_edge = mclk_level && !mclk_last_q;
	wire bclk_edge = bclk_level && !bclk_last_q;

	// ------------------------------------------------------------------------
	// Source selection
	// ------------------------------------------------------------------------
	wire [1:0] conv_src = clock_source_select_q[`CONV_SRC_LSB+1:`CONV_SRC_LSB];
	wire [1:0] pll_src  = clock_source_select_q[`PLL_SRC_LSB+1:`PLL_SRC_LSB];
	reg        pll_reference_input;
	reg        conv_ref_d;

	// Unused source codes select nothing; the PLL or the cascade they feed then sees no ticks.
	always @* begin
		case (pll_src)
			`SRC_MCLK: pll_reference_input = mclk_edge;
			`SRC_BCLK: pll_reference_input = bclk_edge;
			default:   pll_reference_input = 1'b0;
		endcase
		case (conv_src)
			`SRC_MCLK: conv_ref_d = mclk_edge;
			`SRC_BCLK: conv_ref_d = bclk_edge;
			`SRC_PLL:  conv_ref_d = pll_tick;
			default:   conv_ref_d = 1'b0;
		endcase
	end

	// Registering the selected reference gives every source the same latency.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			converter_reference_tick <= 1'b0;
		end else begin
			converter_reference_tick <= conv_ref_d;
		end
	end

	// ------------------------------------------------------------------------
	// Fractional PLL rate model
	// ------------------------------------------------------------------------
	// Each divided reference edge adds K*R*10000 credit; one output tick is
	// released per cycle while 10000 credit remains, so the long-run tick rate
	// is reference*K*R/P exactly, including the four-digit fraction.
	wire        pll_enable = pll_pr_q[`PLL_EN_BIT];
	wire [2:0]  p_field    = pll_pr_q[`PLL_P_LSB+2:`PLL_P_LSB];
	wire [3:0]  r_field    = pll_pr_q[`PLL_R_LSB+3:`PLL_R_LSB];
	wire [8:0]  p_eff      = (p_field == 3'h0) ? 9'h008 : {6'h00, p_field};
	wire [4:0]  r_eff      = (r_field == 4'h0) ? 5'h10 : {1'b0, r_field};
	wire [19:0] k_scaled   = ({14'h0000, pll_j_q} * `FRAC_SCALE) + {6'h00, pll_d_q};
	wire [24:0] kr_scaled  = {5'h00, k_scaled} * {20'h00000, r_eff};
	wire        pll_pre_tick;
	reg  [25:0] credit_q;
	reg  [25:0] credit_d;
	wire        credit_ready = credit_q >= `CREDIT_SCALE;
	wire [26:0] credit_sum;

	// The pre-divider stops with the PLL, so its phase restarts on enable.
	tick_divider u_pll_prediv (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.enable  (pll_enable),
		.divisor (p_eff),
		.tick_in (pll_reference_input),
		.tick_q  (pll_pre_tick)
	);

	// Drain and fill may meet in one cycle; the drain only runs while a whole
	// tick of credit remains, so the sum never goes negative.
	assign credit_sum = {1'b0, credit_q}
	                  - (credit_ready ? {1'b0, `CREDIT_SCALE} : 27'h0000000)
	                  + (pll_pre_tick ? {2'h0, kr_scaled} : 27'h0000000);

	always @* begin
		// Saturate rather than wrap if the reference outpaces the tick drain.
		// Saturation loses the excess; the host must keep K times R over P small.
		credit_d = credit_sum[26] ? `CREDIT_MAX : credit_sum[25:0];
	end

	// Disabling the PLL drops stored credit, so re-enabling starts empty.
	always @(posedge sys_clk) begin
		if (!rst_b) begin
			credit_q <= 26'h0000000;
			pll_tick <= 1'b0;
		end else if (!pll_enable) begin
			credit_q <= 26'h0000000;
			pll_tick <= 1'b0;
		end else begin
			credit_q <= credit_d;
			pll_tick <= credit_ready;
		end
	end

	// ------------------------------------------------------------------------
	// Cascaded dividers
	// ------------------------------------------------------------------------
	// A zero field stands for the largest divisor; only the enable bit stops a stage.
	wire [8:0] conv_divisor = (conv_div_q[6:0] == 7'h00) ? 9'h080 : {2'h0, conv_div_q[6:0]};
	wire [8:0] mod_divisor  = (mod_div_q[6:0] == 7'h00) ? 9'h080 : {2'h0, mod_div_q[6:0]};
	wire [8:0] ovs_divisor  = (oversampling_q == 8'h00) ? 9'h100 : {1'b0, oversampling_q};

	// The converter stage counts reference ticks; each stage adds one cycle.
	tick_divider u_conv_div (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.enable  (conv_div_q[`DIV_EN_BIT]),
		.divisor (conv_divisor),
		.tick_in (converter_reference_tick),
		.tick_q  (converter_clock_tick)
	);

	tick_divider u_mod_div (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.enable  (mod_div_q[`DIV_EN_BIT]),
		.divisor (mod_divisor),
		.tick_in (converter_clock_tick),
		.tick_q  (modulator_clock_tick)
	);

	// The oversampling stage shares the modulator enable, so one bit gates both.
	tick_divider u_oversampling (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.enable  (mod_div_q[`DIV_EN_BIT]),
		.divisor (ovs_divisor),
		.tick_in (modulator_clock_tick),
		.tick_q  (sample_tick)
	);

	// ------------------------------------------------------------------------
	// Master clock sufficiency monitor
	// ------------------------------------------------------------------------
	// Counts converter clock ticks per sample and flags a shortfall against the
	// instruction budget; the host must correct the setup, the block only reports.
	reg  [15:0] conv_count_q;
	// Filter mode zero takes the budget from the register, any other a fixed one.
	wire [15:0] instr_needed = (filter_mode_select_q == 8'h00)
	                         ? {8'h00, instruction_count_setting_q}
	                         : `PROC_BLOCK_INSTR;
	// The count saturates, so a very slow sample clock reads as a large count.
	wire [15:0] conv_count_inc = (conv_count_q == 16'hffff) ? conv_count_q
	                           : conv_count_q + 16'h0001;

	always @(posedge sys_clk) begin
		if (!rst_b) begin
			conv_count_q      <= 16'h0000;
			conv_per_sample_q <= 16'h0000;
			clock_rate_low    <= 1'b0;
		end else if (sample_tick) begin
			conv_count_q      <= converter_clock_tick ? 16'h0001 : 16'h0000;
			conv_per_sample_q <= conv_count_q;
			clock_rate_low    <= conv_count_q < instr_needed;
		end else if (converter_clock_tick) begin
			conv_count_q <= conv_count_inc;
		end
	end

endmodule
`default_nettype wire

// file: verification/ref_clock_source.sv
// Model of the external sources that drive the master and bit clock pins.
`timescale 1ns/100ps
`default_nettype none
module ref_clock_source (
	input  wire logic [7:0] mclk_half,
	input  wire logic [7:0] bclk_half,
	output var  logic       mclk_pin,
	output var  logic       bclk_pin
);
	// ------------------------------------------------------------------
	// Free-running sources
	// ------------------------------------------------------------------
	// Half periods count 25 ns steps; two or more keep each phase long
	// enough for the pin synchronisers. Zero parks the pin low.
	// The odd start offsets keep both sources out of phase with sys_clk.
	initial begin
		mclk_pin = 1'b0;
		#7;
		forever begin
			if (mclk_half == 8'h00) begin
				mclk_pin = 1'b0;
				#25;
			end else begin
				#(mclk_half * 25) mclk_pin = ~mclk_pin;
			end
		end
	end

	initial begin
		bclk_pin = 1'b0;
		#11;
		forever begin
			if (bclk_half == 8'h00) begin
				bclk_pin = 1'b0;
				#25;
			end else begin
				#(bclk_half * 25) bclk_pin = ~bclk_pin;
			end
		end
	end
endmodule
`default_nettype wire

// file: verification/audio_clock_generator_pll_assertions.sv
// Checker of the audio clock generator's port behaviour.
`timescale 1ns/100ps
`default_nettype none
module audio_clock_generator_pll_assertions (
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        mclk_pin,
	input wire logic        bclk_pin,
	input wire logic        pll_tick,
	input wire logic        converter_reference_tick,
	input wire logic        converter_clock_tick,
	input wire logic        modulator_clock_tick,
	input wire logic        sample_tick,
	input wire logic        clock_rate_low
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------------
	// Divider cascade
	// ------------------------------------------------------------------
	sequence s_chain;
		converter_reference_tick ##1 converter_clock_tick ##1 modulator_clock_tick;
	endsequence

	property p_cc_cause;
		converter_clock_tick |-> $past(converter_reference_tick);
	endproperty
	a_cc_cause: assert property (p_cc_cause) else $error("converter tick without reference");

	property p_mod_cause;
		modulator_clock_tick |-> $past(converter_clock_tick);
	endproperty
	a_mod_cause: assert property (p_mod_cause) else $error("modulator tick without cause");

	property p_fs_cause;
		sample_tick |-> $past(modulator_clock_tick);
	endproperty
	a_fs_cause: assert property (p_fs_cause) else $error("sample tick without cause");

	property p_chain_depth;
		sample_tick |-> $past(converter_reference_tick, 3);
	endproperty
	a_chain_depth: assert property (p_chain_depth) else $error("sample tick not three after ref");

	property p_rate_low;
		$changed(clock_rate_low) |-> sample_tick || $past(sample_tick);
	endproperty
	a_rate_low: assert property (p_rate_low) else $error("rate flag moved off a sample");

	// ------------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------------
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("access cycle without ready");

	property p_err_zero;
		pslverr |-> prdata == 32'h00000000;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused access returned data");

	property p_rd_hold;
		$changed(prdata) |-> $past(psel && !penable);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved outside a transfer");

	c_chain: cover property (s_chain ##1 sample_tick);
endmodule

bind audio_clock_generator_pll audio_clock_generator_pll_assertions u_chk (
	.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
	.pslverr, .mclk_pin, .bclk_pin, .pll_tick, .converter_reference_tick,
	.converter_clock_tick, .modulator_clock_tick, .sample_tick, .clock_rate_low
);
`default_nettype wire

// file: verification/audio_clock_generator_pll_tb_top.sv
// Self-checking testbench of the audio clock generator.
`timescale 1ns/100ps
`default_nettype none
`include "audio_clock_defines.vh"
module audio_clock_generator_pll_tb_top;
	logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, er;
	logic        mclk_pin, bclk_pin, pll_tick, converter_reference_tick;
	logic        converter_clock_tick, modulator_clock_tick, sample_tick, clock_rate_low;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic [7:0]  mh, bh;
	int          fails, cmp_count, ns, np, nc;
	logic [7:0]  ri [10] = '{`IDX_CLOCK_SOURCE_SELECT, `IDX_PLL_PR, `IDX_PLL_J,
		`IDX_PLL_D_HIGH, `IDX_PLL_D_LOW, `IDX_CONV_DIV, `IDX_MOD_DIV,
		`IDX_OVERSAMPLING, `IDX_INSTRUCTION_COUNT, `IDX_FILTER_MODE_SELECT};
	logic [7:0]  rv [10] = '{`RST_CLOCK_SOURCE_SELECT, `RST_PLL_PR, 8'(`RST_PLL_J), 8'h00,
		8'h00, `RST_CONV_DIV, `RST_MOD_DIV, `RST_OVERSAMPLING, `RST_INSTRUCTION_COUNT,
		`RST_FILTER_MODE_SELECT};

	audio_clock_generator_pll dut (.sys_clk, .rst_b, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .mclk_pin, .bclk_pin, .pll_tick,
		.converter_reference_tick, .converter_clock_tick, .modulator_clock_tick,
		.sample_tick, .clock_rate_low);
	ref_clock_source u_src (.mclk_half(mh), .bclk_half(bh), .mclk_pin, .bclk_pin);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] val);
		apb(1'b1, idx, {24'h000000, val});
	endtask

	task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 32'h00000000);
		chk(er === 1'b0 && rd === {24'h000000, e}, "register read back");
	endtask

	task automatic cnt(input int win);
		ns = 0;
		np = 0;
		nc = 0;
		repeat (win) begin
			@(posedge sys_clk);
			ns += (sample_tick === 1'b1);
			np += (pll_tick === 1'b1);
			nc += (converter_clock_tick === 1'b1);
		end
	endtask

	function automatic logic near(input int got, input int e, input int tol);
		return (got >= e - tol) && (got <= e + tol);
	endfunction

	// Both pins run at different rates so a wrong selection shows as a wrong count.
	task automatic divtest(input logic [7:0] src, input int c, input int m, input int o,
		input int h);
		int e;
		mh <= h[7:0];
		bh <= h[7:0] + 8'h01;
		wr(`IDX_CLOCK_SOURCE_SELECT, src);
		wr(`IDX_CONV_DIV, 8'h80 | c[7:0]);
		wr(`IDX_MOD_DIV, 8'h80 | m[7:0]);
		wr(`IDX_OVERSAMPLING, o[7:0]);
		repeat (200) @(posedge sys_clk);
		cnt(2400);
		e = (src[1:0] == 2'h2) ? 0 : 2400 / (2 * (h + src[0]) * c * m * o);
		chk(near(ns, e, 1), "divided sample rate");
		e = (src[1:0] == 2'h2) ? 0 : 2400 / (2 * (h + src[0]) * c);
		chk(near(nc, e, 1), "divided converter clock rate");
		$display("test divider src %0d done", src);
	endtask

	task automatic plltest(input logic [7:0] src, pr, j, dh, dl, input real rate);
		wr(`IDX_CLOCK_SOURCE_SELECT, src);
		wr(`IDX_PLL_PR, pr);
		wr(`IDX_PLL_J, j);
		wr(`IDX_PLL_D_HIGH, dh);
		wr(`IDX_PLL_D_LOW, dl);
		wr(`IDX_CONV_DIV, 8'h81);
		wr(`IDX_MOD_DIV, 8'h81);
		wr(`IDX_OVERSAMPLING, 8'h04);
		repeat (200) @(posedge sys_clk);
		cnt(3200);
		chk(near(np, int'(rate * 3200.0), 3), "pll tick rate");
		chk(near(ns, int'(rate * 800.0), 2), "pll sample rate");
		$display("test pll %h done", pr);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#(80000 * 25);
		fails++;
		final_report();
	end

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		logic [7:0] ix [3] = '{`IDX_INSTRUCTION_COUNT, `IDX_FILTER_MODE_SELECT, `IDX_OVERSAMPLING};
		fails = 0;
		cmp_count = 0;
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		mh = 8'h04;
		bh = 8'h05;
		void'($urandom(55082));
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int k = 0; k < 10; k++) rdc(ri[k], rv[k]);
		for (int k = 0; k < 3; k++) begin
			v = $urandom;
			wr(ix[k], v[7:0]);
			rdc(ix[k], v[7:0]);
		end
		apb(1'b0, 8'h3e, 32'h00000000);
		chk(er === 1'b1 && rd === 32'h00000000, "unmapped read accepted");
		apb(1'b1, 8'h3e, 32'hffffffff);
		chk(er === 1'b1, "unmapped write accepted");
		wr(`IDX_PLL_D_HIGH, 8'h27);
		wr(`IDX_PLL_D_LOW, 8'hff);
		rdc(`IDX_PLL_D_LOW, 8'h0f);
		rdc(`IDX_PLL_D_HIGH, 8'h27);
		$display("test registers done");
		divtest(8'h00, 2, 2, 4, 4);
		divtest(8'h01, 1, 3, 4, 3);
		divtest(8'h02, 1, 1, 2, 3);
		for (int k = 0; k < 4; k++) begin
			divtest({7'h00, 1'($urandom)}, 1 + $urandom % 3, 1 + $urandom % 3,
				2 + $urandom % 5, 2 + $urandom % 4);
		end
		mh <= 8'h08;
		bh <= 8'h03;
		plltest(8'h03, 8'ha1, 8'h04, 8'h13, 8'h88, 0.140625);
		plltest(8'h03, 8'h80, 8'h04, 8'h00, 8'h00, 0.5);
		plltest(8'h03, 8'h11, 8'h04, 8'h00, 8'h00, 0.0);
		mh <= 8'h03;
		bh <= 8'h08;
		plltest(8'h07, 8'hc1, 8'h0a, 8'h09, 8'hc4, 0.16015625);
		mh <= 8'h04;
		wr(`IDX_CLOCK_SOURCE_SELECT, 8'h00);
		wr(`IDX_CONV_DIV, 8'h81);
		wr(`IDX_MOD_DIV, 8'h82);
		for (int k = 0; k < 3; k++) begin
			wr(`IDX_INSTRUCTION_COUNT, (k == 0) ? 8'h80 : 8'h04);
			wr(`IDX_FILTER_MODE_SELECT, (k == 2) ? 8'h01 : 8'h00);
			repeat (300) @(posedge sys_clk);
			chk(clock_rate_low === (k != 1), "rate flag");
			apb(1'b0, `IDX_CLOCK_STATUS, 32'h00000000);
			chk(er === 1'b0 && rd[16] === (k != 1), "status rate flag");
			chk(rd[15:0] === 16'h0008, "status tick count");
		end
		$display("test rate flag done");
		wr(`IDX_CONV_DIV, 8'h01);
		repeat (100) @(posedge sys_clk);
		cnt(600);
		chk(ns == 0 && nc == 0, "disabled divider ticked");
		$display("test divider enable done");
		final_report();
	end
endmodule
`default_nettype wire
